/* shared/dsf_pkg.sv */
// Constants and carrier types of the converter special-function control.
// Assumes a 25 MHz system clock and a 24-bit serial command word.
package dsf_pkg;

  // Serial word geometry
  localparam int WORD_BITS = 24;
  localparam logic [4:0] WORD_BITS_CNT = 5'h18;
  localparam int DATA_W = 16;
  localparam int N_CH = 8;

  // Mode field of a serial word
  localparam logic [1:0] MODE_SPECIAL = 2'h0;
  localparam logic [1:0] MODE_GAIN = 2'h1;
  localparam logic [1:0] MODE_OFFSET = 2'h2;
  localparam logic [1:0] MODE_DATA = 2'h3;

  // Special function codes (address field when mode is special)
  localparam logic [5:0] SF_CONTROL = 6'h01;
  localparam logic [5:0] SF_READBACK = 6'h05;
  localparam logic [5:0] SF_AB_SEL0 = 6'h06;
  localparam logic [5:0] SF_AB_SEL1 = 6'h07;
  localparam logic [5:0] SF_MONITOR = 6'h0c;
  localparam logic [5:0] SF_GPIO = 6'h0d;

  // Control register fields and reset
  localparam int CTL_PD = 0;
  localparam int CTL_TSD_EN = 1;
  localparam int CTL_AB = 2;
  localparam int CTL_TSD_FLAG = 4;
  localparam logic [4:0] CTL_RST = 5'h00;

  // Monitor select fields and reset
  localparam int MON_EN = 5;
  localparam int MON_KIND = 4;
  localparam int MON_BANK = 3;
  localparam logic [5:0] MON_RST = 6'h00;

  // General pin fields and reset
  localparam int GPIO_DIR = 1;
  localparam int GPIO_LVL = 0;
  localparam logic [1:0] GPIO_RST = 2'h0;

  // Synchronised pin positions and their idle levels
  localparam int PIN_SCLK = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_HOT = 4;
  localparam int PIN_GPIO = 5;
  localparam int PIN_CODING = 6;
  localparam int N_PINS = 7;
  localparam logic [6:0] PIN_IDLE = 7'h0a;

  // Busy timing, rounded down to whole cycles
  localparam int CLK_NS = 40;
  localparam int SEL_BUSY_NS = 600;
  localparam int CALC_BUSY_NS = 1500;
  localparam logic [5:0] SEL_BUSY_CYC = 6'(SEL_BUSY_NS / CLK_NS);
  localparam logic [5:0] CALC_BUSY_CYC = 6'(CALC_BUSY_NS / CLK_NS);

  // Fields of one received serial word
  typedef struct packed {
    logic [1:0] mode;
    logic [5:0] addr;
    logic [15:0] data;
  } dsf_word_t;

  // Monitor switch request: one closed switch at most
  typedef struct packed {
    logic enable;
    logic [1:0] aux;
    logic [7:0] chan;
  } dsf_mon_t;

endpackage

/* rtl/dsf_pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes every input toggles slower than two system clocks.
`timescale 1ns/1ps
module dsf_pin_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Raw pins
  input wire logic [W-1:0] pins,
  // Filtered levels and edge pulses
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } dsf_sync_t;

  dsf_sync_t s_q, s_d;
  logic [W-1:0] agree;

  // A change counts only when stages two and three agree
  always_comb begin
    s_d = s_q;
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    agree = ~(s_q.s2 ^ s_q.s3);
    s_d.lvl = (agree & s_q.s3) | (~agree & s_q.lvl);
  end

  // Edges are one-cycle pulses ahead of the level update
  assign rise = s_d.lvl & ~s_q.lvl;
  assign fall = ~s_d.lvl & s_q.lvl;
  assign level = s_q.lvl;

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= {INIT, INIT, INIT, INIT};
    end else begin
      s_q <= s_d;
    end
  end

endmodule // dsf_pin_sync

/* rtl/dsf_busy_timer.sv */
// Busy-low timer: counts down a loaded number of cycles.
// Assumes start pulses come from logic on the same clock.
`timescale 1ns/1ps
module dsf_busy_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Start request
  input wire logic start,
  input wire logic [5:0] load,
  // Status
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [5:0] cnt;
  } dsf_tmr_t;

  dsf_tmr_t s_q, s_d;

  // A restart never shortens a busy period already running
  always_comb begin
    s_d = s_q;
    if (s_q.cnt != 6'h00) begin
      s_d.cnt = s_q.cnt - 6'h01;
    end
    if (start && load > s_d.cnt) begin
      s_d.cnt = load;
    end
  end

  assign busy = (s_q.cnt != 6'h00);
  assign done = (s_q.cnt == 6'h01) && !start;

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // dsf_busy_timer

/* rtl/dsf_control.sv */
// Special-function control of an eight-channel output converter.
// Assumes serial pins, load strobe, pin and sensor inputs are asynchronous.
`timescale 1ns/1ps
// Behaviour
// (R1) Coding pin low: data straight binary; high: twos complement.
// (R2) Coding applies to data and offset only; gain and commands stay binary.
// (R3) Monitor enable bit one connects monitor output; zero leaves it open.
// (R4) Bank bit and low bits pick channel; kind bit picks auxiliary input.
// (R5) Special code 001101 addresses the general pin register.
// (R6) Direction bit one drives the general pin at the level bit.
// (R7) Writing both bits zero makes the pin an undriven input.
// (R8) Reading the general pin register returns the pin level in bit zero.
// (R9) Control bit zero powers down and grounds all channel outputs.
// (R10) Power-down keeps registers; clearing it restores previous outputs.
// (R11) Bit one set and die too hot enters shutdown like power-down.
// (R12) Entering thermal shutdown sets control bit four.
// (R13) Shutdown persists until the host clears control bit one.
// (R14) Input, gain or offset writes start calculation of A or B.
// (R15) Select register writes pick A or B per channel without recalculation.
// (R16) Each select register carries four channel bits; two writes cover eight.
// (R17) A select register write pulls busy low for about 600 ns.
// (R18) Load strobe low loads each output from A or B per select bit.
// (R19) Mode bits 00 mark a special function command.
// (R20) Busy stays low while a calculated register is computed.
// (R21) Over-temperature input is synchronised before it acts.
// (R22) Undefined monitor codes leave the monitor output disconnected; the code closes no switch but still sets enable from bit five.
module dsf_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial register port
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  // Control pins
  input wire logic coding_select_pin,
  input wire logic load_outputs_n,
  input wire logic over_temp,
  output logic busy_n,
  // General-purpose pin
  input wire logic gpio_i,
  output logic gpio_o,
  output logic gpio_oe,
  // Converter side
  output logic [7:0][15:0] chan_code,
  output logic to_signal_ground_ref,
  output dsf_pkg::dsf_mon_t monitor_route
);

  typedef struct packed {
    logic [23:0] shift;
    logic [4:0] nbits;
    logic [23:0] out_sh;
    logic sdo_oe;
    logic rd_pend;
    logic rd_act;
    logic [5:0] rd_sel;
    logic [4:0] ctl;
    logic [5:0] mon;
    logic [1:0] gpio;
    logic [7:0] absel;
    logic [7:0][15:0] in_a;
    logic [7:0][15:0] in_b;
    logic [7:0][15:0] calc_a;
    logic [7:0][15:0] calc_b;
    logic [7:0][15:0] dac;
    logic calc_pend;
    logic [2:0] calc_ch;
    logic calc_b_sel;
    logic ld_pend;
  } dsf_state_t;

  dsf_state_t s_q, s_d;
  logic [dsf_pkg::N_PINS-1:0] lvl, rise, fall;
  dsf_pkg::dsf_word_t wd;
  logic fire, tmr_start, tmr_busy, tmr_done, load_fire;
  logic [5:0] tmr_load;
  logic [15:0] conv;
  logic [15:0] rd_word;

  // Every asynchronous pin passes the three-stage filter
  dsf_pin_sync #(
    .W(dsf_pkg::N_PINS),
    .INIT(dsf_pkg::PIN_IDLE)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pins({coding_select_pin, gpio_i, over_temp, load_outputs_n,
           sdi, sync_n, sclk}), // Over-temperature filtered [R21]
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // One shared timer: calculation and select-register busy periods
  dsf_busy_timer u_busy (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(tmr_start),
    .load(tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // Readback word selection
  always_comb begin
    rd_word = 16'h0000;
    unique case (s_q.rd_sel)
      dsf_pkg::SF_CONTROL: rd_word = {11'h000, s_q.ctl};
      dsf_pkg::SF_MONITOR: rd_word = {10'h000, s_q.mon};
      dsf_pkg::SF_GPIO: rd_word = {15'h0000, lvl[dsf_pkg::PIN_GPIO]}; // [R8]
      dsf_pkg::SF_AB_SEL0: rd_word = {12'h000, s_q.absel[3:0]};
      dsf_pkg::SF_AB_SEL1: rd_word = {12'h000, s_q.absel[7:4]};
      default: rd_word = 16'h0000;
    endcase
  end

  // Twos complement input becomes offset binary by flipping the sign
  always_comb begin
    wd = dsf_pkg::dsf_word_t'(s_q.shift);
    conv = wd.data;
    if (lvl[dsf_pkg::PIN_CODING] && wd.mode != dsf_pkg::MODE_GAIN) begin
      conv = {~wd.data[15], wd.data[14:0]}; // [R1] [R2]
    end
  end

  assign fire = rise[dsf_pkg::PIN_SYNC] &&
                (s_q.nbits == dsf_pkg::WORD_BITS_CNT);
  // Load waits for calculations; a held-low strobe reloads after busy
  assign load_fire = (s_q.ld_pend || !lvl[dsf_pkg::PIN_LOAD]) &&
                     !tmr_busy && !s_q.calc_pend; // [R18]

  // Next-state logic
  always_comb begin
    s_d = s_q;
    tmr_start = 1'b0;
    tmr_load = dsf_pkg::CALC_BUSY_CYC;
    // Frame start: a pending readback is loaded for shifting out
    if (fall[dsf_pkg::PIN_SYNC]) begin
      s_d.nbits = 5'h00;
      s_d.rd_act = s_q.rd_pend;
      s_d.rd_pend = 1'b0;
      if (s_q.rd_pend) begin
        s_d.out_sh = {8'h00, rd_word};
      end
    end
    // Data in on falling serial edges, out on rising ones
    if (!lvl[dsf_pkg::PIN_SYNC] && fall[dsf_pkg::PIN_SCLK]) begin
      s_d.shift = {s_q.shift[22:0], lvl[dsf_pkg::PIN_SDI]};
      if (s_q.nbits != 5'h1f) begin
        s_d.nbits = s_q.nbits + 5'h01;
      end
    end
    if (!lvl[dsf_pkg::PIN_SYNC] && rise[dsf_pkg::PIN_SCLK] && s_q.rd_act) begin
      s_d.out_sh = {s_q.out_sh[22:0], 1'b0};
    end
    // Calculation result lands when its busy period ends
    if (tmr_done && s_q.calc_pend) begin
      s_d.calc_pend = 1'b0;
      if (s_q.calc_b_sel) begin
        s_d.calc_b[s_q.calc_ch] = s_q.in_b[s_q.calc_ch];
      end else begin
        s_d.calc_a[s_q.calc_ch] = s_q.in_a[s_q.calc_ch];
      end
    end
    // Frame end: release the output, then act on a full word
    if (rise[dsf_pkg::PIN_SYNC] && s_q.rd_act) begin
      s_d.rd_act = 1'b0;
      s_d.sdo_oe = 1'b0;
    end
    if (fire) begin
      if (wd.mode == dsf_pkg::MODE_SPECIAL) begin // [R19]
        unique case (wd.addr)
          dsf_pkg::SF_CONTROL: begin
            s_d.ctl[2:0] = wd.data[2:0];
            if (!wd.data[dsf_pkg::CTL_TSD_EN]) begin
              s_d.ctl[dsf_pkg::CTL_TSD_FLAG] = 1'b0; // [R13]
            end
          end
          dsf_pkg::SF_MONITOR: s_d.mon = wd.data[5:0];
          dsf_pkg::SF_GPIO: s_d.gpio = wd.data[1:0]; // [R5]
          dsf_pkg::SF_AB_SEL0: begin
            s_d.absel[3:0] = wd.data[3:0]; // [R15] [R16]
            tmr_start = 1'b1;
            tmr_load = dsf_pkg::SEL_BUSY_CYC; // [R17]
          end
          dsf_pkg::SF_AB_SEL1: begin
            s_d.absel[7:4] = wd.data[3:0]; // [R16]
            tmr_start = 1'b1;
            tmr_load = dsf_pkg::SEL_BUSY_CYC; // [R17]
          end
          dsf_pkg::SF_READBACK: begin
            s_d.rd_pend = 1'b1;
            s_d.sdo_oe = 1'b1;
            s_d.rd_sel = wd.data[5:0];
          end
          default: ;
        endcase
      end else begin
        // Data, gain and offset writes all restart the calculation
        if (wd.mode == dsf_pkg::MODE_DATA) begin
          if (s_q.ctl[dsf_pkg::CTL_AB]) begin
            s_d.in_b[wd.addr[2:0]] = conv;
          end else begin
            s_d.in_a[wd.addr[2:0]] = conv;
          end
        end
        s_d.calc_pend = 1'b1; // [R14]
        s_d.calc_ch = wd.addr[2:0];
        s_d.calc_b_sel = s_q.ctl[dsf_pkg::CTL_AB];
        tmr_start = 1'b1;
      end
    end
    // Hot die with shutdown armed: flag sticks; a write clearing bit one wins over set
    if (lvl[dsf_pkg::PIN_HOT] && s_d.ctl[dsf_pkg::CTL_TSD_EN]) begin
      s_d.ctl[dsf_pkg::CTL_TSD_FLAG] = 1'b1; // [R11] [R12]
    end
    // Strobe edge is remembered while busy
    if (fall[dsf_pkg::PIN_LOAD]) begin
      s_d.ld_pend = 1'b1;
    end
    if (load_fire) begin
      s_d.ld_pend = fall[dsf_pkg::PIN_LOAD];
      for (int i = 0; i < dsf_pkg::N_CH; i++) begin
        s_d.dac[i] = s_q.absel[i] ? s_q.calc_b[i] : s_q.calc_a[i]; // [R18]
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.ctl <= dsf_pkg::CTL_RST;
      s_q.mon <= dsf_pkg::MON_RST;
      s_q.gpio <= dsf_pkg::GPIO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Monitor switch decode; unlisted codes close no switch
  always_comb begin
    monitor_route = '0;
    monitor_route.enable = s_q.mon[dsf_pkg::MON_EN]; // [R3]
    if (s_q.mon[dsf_pkg::MON_EN]) begin
      if (!s_q.mon[dsf_pkg::MON_KIND] && !s_q.mon[2]) begin
        monitor_route.chan[{s_q.mon[dsf_pkg::MON_BANK], s_q.mon[1:0]}] =
          1'b1; // [R4]
      end else if (s_q.mon[dsf_pkg::MON_KIND] && s_q.mon[3:1] == 3'h0) begin
        monitor_route.aux[s_q.mon[0]] = 1'b1; // [R4] [R22]
      end
    end
  end

  // Outputs: registers stay intact while outputs sit at ground
  assign to_signal_ground_ref = s_q.ctl[dsf_pkg::CTL_PD] ||
    (s_q.ctl[dsf_pkg::CTL_TSD_EN] &&
     s_q.ctl[dsf_pkg::CTL_TSD_FLAG]); // [R9] [R10] [R11]
  assign chan_code = s_q.dac;
  assign busy_n = !(tmr_busy || s_q.calc_pend); // [R20]
  assign gpio_oe = s_q.gpio[dsf_pkg::GPIO_DIR]; // [R6] [R7]
  assign gpio_o = s_q.gpio[dsf_pkg::GPIO_LVL]; // [R6]
  assign sdo_o = s_q.out_sh[23];
  assign sdo_oe = s_q.sdo_oe;

  default clocking dsf_cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  pd_ground_a: assert property ( // [R9]
    fire && wd.mode == 2'h0 && wd.addr == 6'h01 && wd.data[0]
    |=> to_signal_ground_ref)
    else $error("power-down did not ground the outputs");
  regs_kept_a: assert property ( // [R10]
    to_signal_ground_ref && !load_fire |=> $stable(chan_code))
    else $error("output codes changed during power-down");
  tsd_enter_a: assert property ( // [R11]
    lvl[4] && s_q.ctl[1] && !fire |=> to_signal_ground_ref)
    else $error("hot die did not shut the outputs down");
  tsd_flag_a: assert property ( // [R12]
    $rose(lvl[4]) && s_q.ctl[1] && !fire |=> s_q.ctl[4])
    else $error("shutdown flag not set");
  tsd_hold_a: assert property ( // [R13]
    s_q.ctl[4] && s_q.ctl[1] && !fire |=> s_q.ctl[4])
    else $error("shutdown ended without host clear");
  mon_off_a: assert property ( // [R3]
    !s_q.mon[5] |-> monitor_route == '0)
    else $error("monitor driven while disabled");
  mon_chan_a: assert property ( // [R4]
    s_q.mon[5] && s_q.mon[4:2] == 3'h1 |-> monitor_route.chan == 8'h00)
    else $error("monitor picked a channel for an unlisted code");
  mon_bad_a: assert property ( // [R22]
    s_q.mon[5] && s_q.mon[4] && s_q.mon[3:1] != 3'h0
    |-> monitor_route.aux == 2'h0 && monitor_route.chan == 8'h00)
    else $error("unlisted monitor code closed a switch");
  gpio_drive_a: assert property ( // [R6]
    fire && wd.mode == 2'h0 && wd.addr == 6'h0d && wd.data[1]
    |=> gpio_oe && gpio_o == $past(wd.data[0]))
    else $error("general pin not driven as written");
  gpio_in_a: assert property ( // [R7]
    fire && wd.mode == 2'h0 && wd.addr == 6'h0d && wd.data[1:0] == 2'h0
    |=> !gpio_oe)
    else $error("general pin still driven after input write");
  sel_busy_a: assert property ( // [R17]
    fire && wd.mode == 2'h0 && wd.addr[5:1] == 5'h03 |=> !busy_n [*8])
    else $error("select write did not hold busy low");
  calc_busy_a: assert property ( // [R20]
    fire && wd.mode != 2'h0 |=> !busy_n [*8] ##[1:40] busy_n)
    else $error("calculation busy period wrong");
  load_src_a: assert property ( // [R18]
    load_fire |=> chan_code[0] ==
      ($past(s_q.absel[0]) ? $past(s_q.calc_b[0]) : $past(s_q.calc_a[0])))
    else $error("output loaded from the wrong calculated register");

  pd_c: cover property ($rose(to_signal_ground_ref));
  tsd_c: cover property ($rose(s_q.ctl[4]));
  read_c: cover property ($fell(sdo_oe));
  load_c: cover property (load_fire && s_q.absel != 8'h00);

endmodule // dsf_control

/* verification/dsf_host_model.sv */
// Host controller model that shifts 24-bit words over the serial port.
// Assumes the 25 MHz bench clock; one serial clock period is 8 cycles.
`timescale 1ns/1ps
module dsf_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  // Captured readback word
  output logic [23:0] rd_word,
  output logic rd_valid
);
  // Serial clock parks low; it runs only inside frames
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
    rd_word = 24'h0;
    rd_valid = 1'b0;
  end

  // Half a serial period, launched just after a system edge
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // One frame, mode bits first; sdo read just before each rise
  task automatic frame(input logic [23:0] w);
    logic rd;
    rd = sdo_oe;
    sync_n = 1'b0;
    half();
    for (int i = 23; i >= 0; i--) begin
      half();
      rd_word[i] = sdo_oe ? sdo_o : ~sdo_o; // Released line reads inverted
      sclk = 1'b1;
      sdi = w[i];
      half();
      sclk = 1'b0;
    end
    half();
    sync_n = 1'b1;
    sdi = ~sdi;  // Released line must not show the last bit
    rd_valid = rd;
    @(posedge clk_sys);
    #1;
    rd_valid = 1'b0;
  endtask
endmodule // dsf_host_model

/* verification/dsf_control_bench.sv */
// Self-checking bench of the special-function control block.
// Assumes the host model drives the serial pins; readbacks go via a queue.
`timescale 1ns/1ps
module dsf_control_bench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic sclk, sync_n, sdi, sdo_o, sdo_oe, busy_n, gpio_o, gpio_oe, tsg;
  logic coding = 1'b0;
  logic load_n = 1'b1;
  logic hot = 1'b0;
  logic gpio_i = 1'b0;
  logic [7:0][15:0] chan_code;
  dsf_pkg::dsf_mon_t route;
  logic [23:0] rd_word;
  logic rd_valid;
  logic [47:0] notes[$];
  int num_errors = 0;
  int comparisons = 0;
  int seed = 90;
  logic [5:0] v;
  logic [15:0] va, vb;

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  dsf_control dsf_control_i (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk),
    .sync_n(sync_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .coding_select_pin(coding), .load_outputs_n(load_n), .over_temp(hot),
    .busy_n(busy_n), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .chan_code(chan_code), .to_signal_ground_ref(tsg),
    .monitor_route(route));
  dsf_host_model dsf_host_model_i (.clk_sys(clk_sys), .sclk(sclk),
    .sync_n(sync_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .rd_word(rd_word), .rd_valid(rd_valid));

  // Single comparison point
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Readback watcher: oldest note holds mask and value
  always @(posedge clk_sys) begin : watch
    logic [47:0] n;
    if (rd_valid === 1'b1) begin
      n = (notes.size() > 0) ? notes.pop_front() : 48'hffffff_ffffff;
      check(rd_word & n[47:24], n[23:0]);
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic sf(input logic [5:0] a, input logic [15:0] d);
    dsf_control_bench.dsf_host_model_i.frame({dsf_pkg::MODE_SPECIAL, a, d});
    tick(8);
  endtask

  // Readback request, then a dummy frame with an unused code
  task automatic rb(input logic [5:0] c, input logic [23:0] m,
                    input logic [23:0] e);
    sf(dsf_pkg::SF_READBACK, {10'h0, c});
    notes.push_back({m, e});
    sf(6'h00, 16'h0);
  endtask

  // Frame, then measure the busy-low span in cycles
  task automatic timed(input logic [23:0] w, input logic [5:0] e);
    int n;
    n = 0;
    dsf_control_bench.dsf_host_model_i.frame(w);
    for (int i = 0; i < 20 && busy_n !== 1'b0; i++) tick(1);
    while (busy_n === 1'b0 && n < 100) begin
      n++;
      tick(1);
    end
    check(24'(n), 24'(e));
    tick(4);
  endtask

  task automatic load();
    load_n = 1'b0;
    tick(8);
    load_n = 1'b1;
    tick(8);
  endtask

  // Sensor pulse longer than the synchroniser delay
  task automatic hot_pulse();
    hot = 1'b1;
    tick(6);
    hot = 1'b0;
    tick(6);
  endtask

  function automatic dsf_pkg::dsf_mon_t mon_exp(input logic [5:0] m);
    mon_exp = '0;
    mon_exp.enable = m[5];
    if (m[5] && !m[4] && !m[2]) mon_exp.chan = 8'h1 << {m[3], m[1:0]};
    if (m[5] && m[4] && m[3:1] == 3'h0) mon_exp.aux = 2'h1 << m[0];
  endfunction

  task automatic complete_run();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog well beyond the expected run of under 1 ms
  initial begin
    #3000000;
    num_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    tick(2);
    nrst = 1'b1;
    tick(6);
    check({sdo_oe, gpio_oe, busy_n, tsg, route}, 24'h1000);
    // Table rows first, then two undefined codes, then random codes
    for (int i = 0; i < 28; i++) begin
      v = (i < 12) ? 6'h20 + 6'(i + 4 * (i / 4)) : 6'($random(seed));
      sf(dsf_pkg::SF_MONITOR, {10'h0, v});
      check(route, mon_exp(v));
    end
    rb(dsf_pkg::SF_MONITOR, 24'h3f, {18'h0, v});
    // General pin: output low, output high, back to input
    sf(dsf_pkg::SF_GPIO, 16'h2);
    check({gpio_oe, gpio_o}, 24'h2);
    sf(dsf_pkg::SF_GPIO, 16'h3);
    check({gpio_oe, gpio_o}, 24'h3);
    sf(dsf_pkg::SF_GPIO, 16'h0);
    check(gpio_oe, 24'h0);
    for (int i = 0; i < 3; i++) begin
      gpio_i = 1'($random(seed));
      tick(6);
      rb(dsf_pkg::SF_GPIO, 24'h1, {23'h0, gpio_i});
    end
    // Toggle between A and B on one channel of each select register
    for (int c = 2; c < 8; c += 4) begin
      va = 16'($random(seed));
      vb = 16'($random(seed));
      sf(dsf_pkg::SF_CONTROL, 16'h0);
      timed({dsf_pkg::MODE_DATA, 6'(c), va}, dsf_pkg::CALC_BUSY_CYC);
      timed({dsf_pkg::MODE_GAIN, 6'(c), 16'hffff},
            dsf_pkg::CALC_BUSY_CYC);
      timed({dsf_pkg::MODE_OFFSET, 6'(c), 16'h8000},
            dsf_pkg::CALC_BUSY_CYC);
      sf(dsf_pkg::SF_CONTROL, 16'h4);
      coding = 1'b1;
      timed({dsf_pkg::MODE_DATA, 6'(c), vb}, dsf_pkg::CALC_BUSY_CYC);
      coding = 1'b0;
      load();
      check(chan_code[c], va);
      timed({dsf_pkg::MODE_SPECIAL, (c < 4) ? dsf_pkg::SF_AB_SEL0 :
             dsf_pkg::SF_AB_SEL1, 16'(1 << (c % 4))},
            dsf_pkg::SEL_BUSY_CYC);
      load();
      check(chan_code[c], vb ^ 16'h8000);
    end
    // Power-down keeps the output register
    sf(dsf_pkg::SF_CONTROL, 16'h1);
    check({tsg, chan_code[6]}, {1'b1, vb ^ 16'h8000});
    sf(dsf_pkg::SF_CONTROL, 16'h0);
    check({tsg, chan_code[6]}, {1'b0, vb ^ 16'h8000});
    // Heat without enable does nothing; with enable it latches
    hot_pulse();
    check(tsg, 24'h0);
    sf(dsf_pkg::SF_CONTROL, 16'h2);
    hot_pulse();
    check(tsg, 24'h1);
    rb(dsf_pkg::SF_CONTROL, 24'h1f, 24'h12);
    check(tsg, 24'h1);
    sf(dsf_pkg::SF_CONTROL, 16'h0);
    check(tsg, 24'h0);
    rb(dsf_pkg::SF_CONTROL, 24'h1f, 24'h0);
    tick(20);
    check(24'(notes.size()), 24'h0);
    complete_run();
  end
endmodule // dsf_control_bench
